/* File: logic/echo_ctrl_regs.sv */
// Purpose: Echo canceller control register bank on classic Wishbone
// Assumes: Event inputs are one-cycle pulses synchronous to core_clk
// Notes:   Configuration words are routed by the select code in bits 3-0
//
// Overview of operation
// (RULE1) Acoustic full-duplex needs ERLE above loss threshold
// (RULE2) Loud near-end noise uses loss threshold, else estimate
// (RULE3) Zero acoustic noise code: loss threshold only
// (RULE4) Network full-duplex needs ERLE above loss threshold
// (RULE5) Loud far-end noise uses loss threshold, else estimate
// (RULE6) Zero network noise code: loss threshold only
// (RULE7) Nonzero network noise code, no path: canceller off
// (RULE8) Receive gain code drives receive input amplifier
// (RULE9) Transmit gain code drives transmit input amplifier
// (RULE10) Instability clears both cancellers unless howl off
// (RULE11) Tone in half-duplex clears acoustic, forces receive
// (RULE12) Tone in full-duplex briefly freezes acoustic coefficients
// (RULE13) Acoustic path change clears acoustic unless off
// (RULE14) Network path change clears network unless off
// (RULE15) Emphasis filters active unless their off bits set
// (RULE16) Acoustic canceller off removes it from decision
// (RULE17) Network canceller off removes it from decision
// (RULE18) Acoustic sidetone code sets acoustic coupling level
// (RULE19) Network sidetone code sets network coupling level
// (RULE20) Low nibble select code routes upper twelve bits
// (RULE21) Reset clears every field to zero code
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`default_nettype none

module echo_ctrl_regs
	import echo_ctrl_pkg::*;
#(
	parameter int unsigned FREEZE_LEN = FREEZE_CYCLES
)
(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Canceller measurements from the signal core
	input  wire logic [7:0]  acoustic_erle_db,
	input  wire logic [7:0]  near_noise_db,
	input  wire logic        acoustic_asym_ok,
	input  wire logic [7:0]  network_erle_db,
	input  wire logic [7:0]  far_noise_db,
	input  wire logic        network_asym_ok,
	input  wire logic        network_path_present,
	input  wire logic        duplex_is_full,
	// Detector events
	input  wire logic        instability_event,
	input  wire logic        tone_event,
	input  wire logic        acoustic_path_event,
	input  wire logic        network_path_event,
	// Controls to the signal core
	output logic             full_duplex_permit,
	output logic             acoustic_coeff_clear,
	output logic             network_coeff_clear,
	output logic             acoustic_coeff_freeze,
	output logic             half_duplex_force,
	output logic             receive_mode_force,
	output logic             acoustic_canceller_enable,
	output logic             network_canceller_enable,
	output logic             acoustic_emphasis_enable,
	output logic             network_emphasis_enable,
	output logic      [1:0]  receive_input_gain,
	output logic      [1:0]  transmit_input_gain,
	output logic      [1:0]  acoustic_sidetone_level,
	output logic      [1:0]  network_sidetone_level
);

	localparam int unsigned FW = 16;

	// ------------------------------------------------------------
	// Configuration storage
	// ------------------------------------------------------------
	logic [11:0] duplex_threshold_gain_config;
	logic [11:0] detector_disable_sidetone_config;
	logic        bad_select;
	logic [11:0] next_duplex;
	logic [11:0] next_detector;
	logic        next_bad_select;

	logic        bus_req;
	logic        bus_wr;
	logic        half_lanes;
	logic [3:0]  wr_select;

	// Field views
	logic [1:0]  acoustic_loss_threshold;
	logic [1:0]  acoustic_noise_threshold;
	logic [1:0]  network_loss_threshold;
	logic [1:0]  network_noise_threshold;
	logic        howl_detector_off;
	logic        tone_detector_off;
	logic        acoustic_path_change_off;
	logic        network_path_change_off;
	logic        acoustic_emphasis_off;
	logic        network_emphasis_off;
	logic        acoustic_canceller_off;
	logic        network_canceller_off;

	assign acoustic_loss_threshold  = duplex_threshold_gain_config[POS_ACOUSTIC_LOSS-4 +: 2];
	assign acoustic_noise_threshold = duplex_threshold_gain_config[POS_ACOUSTIC_NOISE-4 +: 2];
	assign network_loss_threshold   = duplex_threshold_gain_config[POS_NETWORK_LOSS-4 +: 2];
	assign network_noise_threshold  = duplex_threshold_gain_config[POS_NETWORK_NOISE-4 +: 2];
	assign howl_detector_off        = detector_disable_sidetone_config[POS_HOWL_OFF-4];
	assign tone_detector_off        = detector_disable_sidetone_config[POS_TONE_OFF-4];
	assign acoustic_path_change_off = detector_disable_sidetone_config[POS_ACOUSTIC_PC_OFF-4];
	assign network_path_change_off  = detector_disable_sidetone_config[POS_NETWORK_PC_OFF-4];
	assign acoustic_emphasis_off    = detector_disable_sidetone_config[POS_ACOUSTIC_EMPH_OFF-4];
	assign network_emphasis_off     = detector_disable_sidetone_config[POS_NETWORK_EMPH_OFF-4];
	assign acoustic_canceller_off   = detector_disable_sidetone_config[POS_ACOUSTIC_EC_OFF-4];
	assign network_canceller_off    = detector_disable_sidetone_config[POS_NETWORK_EC_OFF-4];

	// Codes go straight from the stored fields to the analog and sidetone paths
	assign receive_input_gain      = duplex_threshold_gain_config[POS_RECEIVE_GAIN-4 +: 2]; // RULE8
	assign transmit_input_gain     = duplex_threshold_gain_config[POS_TRANSMIT_GAIN-4 +: 2]; // RULE9
	assign acoustic_sidetone_level = detector_disable_sidetone_config[POS_ACOUSTIC_SIDETONE-4 +: 2]; // RULE18
	assign network_sidetone_level  = detector_disable_sidetone_config[POS_NETWORK_SIDETONE-4 +: 2]; // RULE19

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// Ack low in the request's first cycle so each access is taken once
	assign bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr     = bus_req && wb_we_i;
	assign half_lanes = wb_sel_i[0] && wb_sel_i[1];
	assign wr_select  = wb_dat_i[3:0];

	always_comb begin
		next_duplex     = duplex_threshold_gain_config;
		next_detector   = detector_disable_sidetone_config;
		next_bad_select = bad_select;
		if (bus_wr && half_lanes && wb_adr_i == OFS_COMMAND) begin
			unique case (wr_select) // RULE20
				SEL_DUPLEX:   next_duplex = wb_dat_i[FW-1:4];
				SEL_DETECTOR: next_detector = wb_dat_i[FW-1:4];
				default:      next_bad_select = 1'b1;
			endcase
		end else if (bus_wr && wb_sel_i[0] && wb_adr_i == OFS_STATUS && wb_dat_i[POS_ST_BAD_SELECT]) begin
			next_bad_select = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			duplex_threshold_gain_config     <= RST_DUPLEX; // RULE21
			detector_disable_sidetone_config <= RST_DETECTOR; // RULE21
			bad_select                       <= 1'b0;
		end else begin
			duplex_threshold_gain_config     <= next_duplex;
			detector_disable_sidetone_config <= next_detector;
			bad_select                       <= next_bad_select;
		end
	end

	// ------------------------------------------------------------
	// Full-duplex decision
	// ------------------------------------------------------------
	logic acoustic_allow;
	logic network_allow;
	logic network_auto_off;
	logic next_permit;

	// Without a detected network path the canceller would only add noise
	assign network_auto_off = (network_noise_threshold != NOISE_ZERO) && !network_path_present; // RULE7

	duplex_gate acoustic_gate (
		.core_clk   (core_clk),
		.resetn     (resetn),
		.erle_db    (acoustic_erle_db),
		.noise_db   (near_noise_db),
		.loss_code  (acoustic_loss_threshold),
		.noise_code (acoustic_noise_threshold),
		.asym_ok    (acoustic_asym_ok),
		.excluded   (acoustic_canceller_off),
		.allow      (acoustic_allow)
	);

	duplex_gate network_gate (
		.core_clk   (core_clk),
		.resetn     (resetn),
		.erle_db    (network_erle_db),
		.noise_db   (far_noise_db),
		.loss_code  (network_loss_threshold),
		.noise_code (network_noise_threshold),
		.asym_ok    (network_asym_ok),
		.excluded   (network_canceller_off || network_auto_off),
		.allow      (network_allow)
	);

	// ------------------------------------------------------------
	// Detector actions and path controls
	// ------------------------------------------------------------
	logic [15:0] freeze_count;
	logic [15:0] next_freeze_count;
	logic        next_a_clear;
	logic        next_n_clear;
	logic        next_half;
	logic        next_rx;
	logic        howl_hit;
	logic        tone_hit;

	assign howl_hit = instability_event && !howl_detector_off;
	assign tone_hit = tone_event && !tone_detector_off;

	always_comb begin
		next_permit       = acoustic_allow && network_allow && !howl_hit; // RULE1 RULE4
		next_a_clear      = 1'b0;
		next_n_clear      = 1'b0;
		next_half         = 1'b0;
		next_rx           = 1'b0;
		next_freeze_count = (freeze_count != 16'h0000) ? freeze_count - 16'h0001 : 16'h0000;
		if (howl_hit) begin // RULE10
			next_a_clear = 1'b1;
			next_n_clear = 1'b1;
			next_half    = 1'b1;
		end
		if (tone_hit && !duplex_is_full) begin // RULE11
			next_a_clear = 1'b1;
			next_rx      = 1'b1;
		end
		if (tone_hit && duplex_is_full) begin // RULE12
			next_freeze_count = FREEZE_LEN[15:0];
		end
		if (acoustic_path_event && !acoustic_path_change_off) begin // RULE13
			next_a_clear = 1'b1;
		end
		if (network_path_event && !network_path_change_off) begin // RULE14
			next_n_clear = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			full_duplex_permit        <= 1'b0;
			acoustic_coeff_clear      <= 1'b0;
			network_coeff_clear       <= 1'b0;
			half_duplex_force         <= 1'b0;
			receive_mode_force        <= 1'b0;
			freeze_count              <= 16'h0000;
			acoustic_coeff_freeze     <= 1'b0;
			acoustic_canceller_enable <= 1'b1;
			network_canceller_enable  <= 1'b1;
			acoustic_emphasis_enable  <= 1'b1;
			network_emphasis_enable   <= 1'b1;
		end else begin
			full_duplex_permit        <= next_permit;
			acoustic_coeff_clear      <= next_a_clear;
			network_coeff_clear       <= next_n_clear;
			half_duplex_force         <= next_half;
			receive_mode_force        <= next_rx;
			freeze_count              <= next_freeze_count;
			acoustic_coeff_freeze     <= next_freeze_count != 16'h0000; // RULE12
			acoustic_canceller_enable <= !acoustic_canceller_off; // RULE16
			network_canceller_enable  <= !network_canceller_off && !network_auto_off; // RULE17 RULE7
			acoustic_emphasis_enable  <= !acoustic_emphasis_off; // RULE15
			network_emphasis_enable   <= !network_emphasis_off; // RULE15
		end
	end

	// ------------------------------------------------------------
	// Wishbone answer
	// ------------------------------------------------------------
	logic [31:0] next_dat;
	logic [31:0] status_word;

	always_comb begin
		status_word                    = 32'h0000_0000;
		status_word[POS_ST_PERMIT]     = full_duplex_permit;
		status_word[POS_ST_NET_AUTO]   = network_auto_off;
		status_word[POS_ST_FREEZE]     = acoustic_coeff_freeze;
		status_word[POS_ST_BAD_SELECT] = bad_select;
		next_dat = 32'h0000_0000;
		if (bus_req && !wb_we_i) begin
			unique case (wb_adr_i)
				OFS_DUPLEX:   next_dat = {16'h0000, duplex_threshold_gain_config, SEL_DUPLEX};
				OFS_DETECTOR: next_dat = {16'h0000, detector_disable_sidetone_config, SEL_DETECTOR};
				OFS_STATUS:   next_dat = status_word;
				default:      next_dat = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= next_dat;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_ack_single: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");

	a_select_route: assert property ( // RULE20
		(bus_wr && half_lanes && wb_adr_i == OFS_COMMAND && wr_select == SEL_DETECTOR)
		|=> detector_disable_sidetone_config == $past(wb_dat_i[15:4]) && wb_ack_o)
		else $error("detector word not routed by select code");

	a_howl_clear: assert property ( // RULE10
		(instability_event && !howl_detector_off)
		|=> acoustic_coeff_clear && network_coeff_clear && half_duplex_force && !full_duplex_permit)
		else $error("instability did not clear both cancellers");

	a_howl_blocked: assert property ( // RULE10
		(instability_event && howl_detector_off) |=> !half_duplex_force)
		else $error("howl detector off still forced half-duplex");

	a_tone_half: assert property ( // RULE11
		(tone_event && !tone_detector_off && !duplex_is_full)
		|=> acoustic_coeff_clear && receive_mode_force)
		else $error("tone in half-duplex did not force receive");

	a_tone_freeze: assert property ( // RULE12
		(tone_event && !tone_detector_off && duplex_is_full && FREEZE_LEN >= 8)
		|=> acoustic_coeff_freeze [*8])
		else $error("tone in full-duplex did not freeze coefficients");

	a_apc_clear: assert property ( // RULE13
		(acoustic_path_event && !acoustic_path_change_off) |=> acoustic_coeff_clear)
		else $error("acoustic path change did not clear");

	a_npc_clear: assert property ( // RULE14
		(network_path_event && !network_path_change_off) |=> network_coeff_clear)
		else $error("network path change did not clear");

	a_net_auto_off: assert property ( // RULE7
		network_auto_off |=> !network_canceller_enable)
		else $error("network canceller not disabled without path");

	a_emph_follow: assert property ( // RULE15
		$changed(detector_disable_sidetone_config)
		|=> acoustic_emphasis_enable == !$past(acoustic_emphasis_off)
		 && network_emphasis_enable == !$past(network_emphasis_off))
		else $error("emphasis enables do not follow their bits");

endmodule

`default_nettype wire

/* File: logic/echo_ctrl_pkg.sv */
// Purpose: Shared constants for the echo canceller control register bank
// Assumes: 25 MHz core clock, 32-bit Wishbone data, 16-bit configuration words
// Notes:   Threshold figures are kept in whole dB as magnitudes
`default_nettype none

package echo_ctrl_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CORE_CLK_HZ    = 25_000_000;
	localparam int unsigned FREEZE_TIME_US = 1000;
	localparam int unsigned FREEZE_CYCLES  = FREEZE_TIME_US * (CORE_CLK_HZ / 1_000_000);

	// ------------------------------------------------------------
	// Wishbone byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_COMMAND  = 8'h00;
	localparam logic [7:0] OFS_DUPLEX   = 8'h04;
	localparam logic [7:0] OFS_DETECTOR = 8'h08;
	localparam logic [7:0] OFS_STATUS   = 8'h0c;

	// ------------------------------------------------------------
	// Select codes carried in bits 3-0 of each configuration word
	// ------------------------------------------------------------
	localparam logic [3:0] SEL_DUPLEX   = 4'h8;
	localparam logic [3:0] SEL_DETECTOR = 4'ha;

	// ------------------------------------------------------------
	// Reset values of the stored fields (bits 15-4)
	// ------------------------------------------------------------
	localparam logic [11:0] RST_DUPLEX   = 12'h000;
	localparam logic [11:0] RST_DETECTOR = 12'h000;

	// ------------------------------------------------------------
	// Field positions, duplex/threshold/gain word
	// ------------------------------------------------------------
	localparam int unsigned POS_ACOUSTIC_LOSS  = 14;
	localparam int unsigned POS_ACOUSTIC_NOISE = 12;
	localparam int unsigned POS_NETWORK_LOSS   = 10;
	localparam int unsigned POS_NETWORK_NOISE  = 8;
	localparam int unsigned POS_RECEIVE_GAIN   = 6;
	localparam int unsigned POS_TRANSMIT_GAIN  = 4;

	// ------------------------------------------------------------
	// Field positions, detector/sidetone word
	// ------------------------------------------------------------
	localparam int unsigned POS_HOWL_OFF          = 15;
	localparam int unsigned POS_TONE_OFF          = 14;
	localparam int unsigned POS_ACOUSTIC_PC_OFF   = 13;
	localparam int unsigned POS_NETWORK_PC_OFF    = 12;
	localparam int unsigned POS_ACOUSTIC_EMPH_OFF = 11;
	localparam int unsigned POS_NETWORK_EMPH_OFF  = 10;
	localparam int unsigned POS_ACOUSTIC_EC_OFF   = 9;
	localparam int unsigned POS_NETWORK_EC_OFF    = 8;
	localparam int unsigned POS_ACOUSTIC_SIDETONE = 6;
	localparam int unsigned POS_NETWORK_SIDETONE  = 4;

	// ------------------------------------------------------------
	// Status register bits
	// ------------------------------------------------------------
	localparam int unsigned POS_ST_PERMIT     = 0;
	localparam int unsigned POS_ST_NET_AUTO   = 1;
	localparam int unsigned POS_ST_FREEZE     = 2;
	localparam int unsigned POS_ST_BAD_SELECT = 3;

	// ------------------------------------------------------------
	// Threshold codes and their dB figures
	// ------------------------------------------------------------
	localparam logic [1:0] LOSS_24DB   = 2'h0;
	localparam logic [1:0] LOSS_18DB   = 2'h1;
	localparam logic [1:0] LOSS_30DB   = 2'h2;
	localparam logic [1:0] NOISE_ZERO  = 2'h0;
	localparam logic [1:0] NOISE_42DB  = 2'h1;
	localparam logic [1:0] NOISE_54DB  = 2'h2;
	localparam logic [7:0] DB_LOSS_24  = 8'h18;
	localparam logic [7:0] DB_LOSS_18  = 8'h12;
	localparam logic [7:0] DB_LOSS_30  = 8'h1e;
	localparam logic [7:0] DB_NOISE_42 = 8'h2a;
	localparam logic [7:0] DB_NOISE_54 = 8'h36;

endpackage

`default_nettype wire

/* File: logic/duplex_gate.sv */
// Purpose: Full-duplex permission for one echo canceller
// Assumes: erle_db is cancellation in dB; noise_db is input noise as dB below full scale
// Notes:   A smaller noise_db means a louder noise floor
`default_nettype none

module duplex_gate
	import echo_ctrl_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [7:0] erle_db,
	input  wire logic [7:0] noise_db,
	input  wire logic [1:0] loss_code,
	input  wire logic [1:0] noise_code,
	input  wire logic       asym_ok,
	input  wire logic       excluded,
	output logic            allow
);

	logic [7:0] loss_db;
	logic       loss_valid;
	logic [7:0] noise_lim;
	logic       noise_used;
	logic       next_allow;

	always_comb begin
		loss_valid = 1'b1;
		loss_db    = DB_LOSS_24;
		unique case (loss_code)
			LOSS_24DB: loss_db = DB_LOSS_24;
			LOSS_18DB: loss_db = DB_LOSS_18;
			LOSS_30DB: loss_db = DB_LOSS_30;
			default:   loss_valid = 1'b0;
		endcase
		noise_used = 1'b1;
		noise_lim  = DB_NOISE_42;
		unique case (noise_code)
			NOISE_42DB: noise_lim = DB_NOISE_42;
			NOISE_54DB: noise_lim = DB_NOISE_54;
			default:    noise_used = 1'b0;
		endcase
		// Noise above the limit, or no limit, leaves the loss threshold in charge
		if (!noise_used || noise_db < noise_lim) begin // RULE2 RULE3 RULE5 RULE6
			next_allow = loss_valid && (erle_db > loss_db); // RULE1 RULE4
		end else begin
			next_allow = asym_ok; // RULE2 RULE5
		end
		// A disabled canceller takes no part in the decision
		if (excluded) begin // RULE16 RULE17
			next_allow = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			allow <= 1'b0;
		end else begin
			allow <= next_allow;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_loss_only: assert property ( // RULE3
		(noise_code == NOISE_ZERO && loss_code == LOSS_24DB && !excluded)
		|=> allow == ($past(erle_db) > DB_LOSS_24))
		else $error("loss threshold not sole criterion with zero noise code");

	a_quiet_asym: assert property ( // RULE2
		(noise_code == NOISE_54DB && noise_db >= DB_NOISE_54 && !excluded)
		|=> allow == $past(asym_ok))
		else $error("quiet input did not defer to asymptotic estimate");

endmodule

`default_nettype wire

/* File: dv/echo_ctrl_regs_bench.sv */
// Purpose: Self-checking bench for the echo canceller control register bank
// Assumes: Ack comes one cycle after the taking edge; FREEZE_LEN cut to 16
// Notes:   Far-end noise is tied low; one asymptotic estimate drives both gates
`default_nettype none
module echo_ctrl_regs_bench
	import echo_ctrl_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic        core_clk = 1'b0;
	logic        resetn   = 1'b0;
	logic        cyc      = 1'b0;
	logic        stb      = 1'b0;
	logic        we       = 1'b0;
	logic [7:0]  adr      = 8'h00;
	logic [31:0] wdat     = 32'h0;
	logic [7:0]  a_erle   = 8'h00;
	logic [7:0]  n_noise  = 8'h00;
	logic [7:0]  n_erle   = 8'h00;
	logic        path_on  = 1'b1;
	logic        full     = 1'b0;
	logic        asym     = 1'b0;
	logic [3:0]  ev       = 4'h0;
	logic [31:0] rd;
	wire  [31:0] rdat;
	wire         ack;
	wire         permit;
	wire  [4:0]  pul;
	wire  [3:0]  en;
	wire  [7:0]  fld;
	int          n_mismatch = 0;
	int          num_checks = 0;
	typedef struct packed { logic [15:0] word; logic [7:0] adr; } row_t;
	row_t        rows [6] = '{'{16'h00d8, OFS_DUPLEX}, '{16'h0068, OFS_DUPLEX}, '{16'h00b8, OFS_DUPLEX},
	                          '{16'h00da, OFS_DETECTOR}, '{16'h006a, OFS_DETECTOR}, '{16'h00ba, OFS_DETECTOR}};

	always #20 core_clk = ~core_clk;

	echo_ctrl_regs #(.FREEZE_LEN(16)) dut (.core_clk(core_clk), .resetn(resetn), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .acoustic_erle_db(a_erle), .near_noise_db(n_noise), .acoustic_asym_ok(asym),
		.network_erle_db(n_erle), .far_noise_db(8'h00), .network_asym_ok(asym),
		.network_path_present(path_on), .duplex_is_full(full), .instability_event(ev[3]),
		.tone_event(ev[2]), .acoustic_path_event(ev[1]), .network_path_event(ev[0]),
		.full_duplex_permit(permit), .acoustic_coeff_clear(pul[4]), .network_coeff_clear(pul[3]),
		.half_duplex_force(pul[2]), .receive_mode_force(pul[1]), .acoustic_coeff_freeze(pul[0]),
		.acoustic_canceller_enable(en[3]), .network_canceller_enable(en[2]),
		.acoustic_emphasis_enable(en[1]), .network_emphasis_enable(en[0]),
		.receive_input_gain(fld[7:6]), .transmit_input_gain(fld[5:4]),
		.acoustic_sidetone_level(fld[3:2]), .network_sidetone_level(fld[1:0]));

	// ------------------------------------------------------------
	// Bus, event and comparison tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Request held until ack is sampled high at a rising edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do @(posedge core_clk); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	task automatic fire(input logic [3:0] e, input logic [4:0] exp);
		@(posedge core_clk);
		ev <= e;
		@(posedge core_clk);
		ev <= 4'h0;
		@(posedge core_clk);
		chk("pulses", exp, pul);
	endtask

	task automatic perm(input logic [15:0] w, input logic [7:0] ae, input logic [7:0] nn, input logic [7:0] ne,
		input logic p, input logic exp);
		wb(1'b1, OFS_COMMAND, {16'h0, w});
		a_erle  <= ae;
		n_noise <= nn;
		n_erle  <= ne;
		path_on <= p;
		repeat (4) @(posedge core_clk);
		chk("permit", exp, permit);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge core_clk);
		n_mismatch++;
		summarize();
	end

	initial begin
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		chk("enables", 4'hf, en);
		chk("fields", 8'h00, fld);
		wb(1'b0, OFS_DUPLEX, 32'h0);
		chk("duplex word", {28'h0, SEL_DUPLEX}, rd);
		$display("reset test done");
		foreach (rows[i]) begin
			wb(1'b1, OFS_COMMAND, {16'h0, rows[i].word});
			wb(1'b0, rows[i].adr, 32'h0);
			chk("readback", {16'h0, rows[i].word}, rd);
			chk("field out", rows[i].word[7:4], rows[i].adr == OFS_DUPLEX ? fld[7:4] : fld[3:0]);
		end
		$display("table test done");
		wb(1'b1, OFS_COMMAND, 32'hfff3);
		wb(1'b0, OFS_DUPLEX, 32'h0);
		chk("bad select", 32'h00b8, rd);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk("bad flag", 1'b1, rd[3]);
		wb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, rd);
		perm(16'h0008, 8'd25, 8'd60, 8'd25, 1'b1, 1'b1);
		perm(16'h0008, 8'd24, 8'd60, 8'd25, 1'b1, 1'b0);
		perm(16'h0008, 8'd25, 8'd60, 8'd24, 1'b1, 1'b0);
		perm(16'h4408, 8'd19, 8'd60, 8'd19, 1'b1, 1'b1);
		perm(16'h8808, 8'd25, 8'd60, 8'd31, 1'b1, 1'b0);
		perm(16'hc008, 8'd99, 8'd60, 8'd25, 1'b1, 1'b0);
		perm(16'h1008, 8'd25, 8'd30, 8'd25, 1'b1, 1'b1);
		perm(16'h1008, 8'd25, 8'd60, 8'd25, 1'b1, 1'b0);
		perm(16'h2008, 8'd25, 8'd50, 8'd25, 1'b1, 1'b1);
		perm(16'h2008, 8'd25, 8'd54, 8'd25, 1'b1, 1'b0);
		asym <= 1'b1;
		perm(16'h2008, 8'd0, 8'd54, 8'd25, 1'b1, 1'b1);
		asym <= 1'b0;
		perm(16'h0108, 8'd25, 8'd60, 8'd00, 1'b1, 1'b0);
		perm(16'h0108, 8'd25, 8'd60, 8'd00, 1'b0, 1'b1);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk("auto off", 1'b1, rd[1]);
		wb(1'b1, OFS_COMMAND, 32'h0c0a);
		repeat (3) @(posedge core_clk);
		chk("enables", 4'h8, en);
		wb(1'b1, OFS_COMMAND, 32'h030a);
		perm(16'h0008, 8'd0, 8'd60, 8'd0, 1'b1, 1'b1);
		chk("enables", 4'h3, en);
		$display("permit test done");
		wb(1'b1, OFS_COMMAND, 32'h000a);
		fire(4'h8, 5'b11100);
		fire(4'h4, 5'b10010);
		fire(4'h2, 5'b10000);
		fire(4'h1, 5'b01000);
		full <= 1'b1;
		fire(4'h4, 5'b00001);
		repeat (12) @(posedge core_clk);
		chk("freeze", 1'b1, pul[0]);
		repeat (8) @(posedge core_clk);
		chk("freeze", 1'b0, pul[0]);
		wb(1'b1, OFS_COMMAND, 32'hb00a);
		fire(4'h8, 5'b00000);
		fire(4'h3, 5'b00000);
		$display("event test done");
		summarize();
	end
endmodule
`default_nettype wire
